// File: rtl/sml_pkg.sv
package sml_pkg;
    // ------------------------------------------------------------
    // register map (word aligned byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] SML_OFS_STATUS = 4'h0;
    localparam logic [3:0] SML_OFS_IRQ_STAT = 4'h4;
    localparam logic [3:0] SML_OFS_IRQ_MASK = 4'h8;
    localparam logic [3:0] SML_OFS_CTRL = 4'hC;

    // status field positions
    localparam int SML_ST_LOCKED = 0;
    localparam int SML_ST_ASI = 1;
    localparam int SML_ST_RATE_SD = 2;
    localparam int SML_ST_MASTER = 3;
    localparam int SML_ST_CARRIER_OK = 4;
    localparam int SML_ST_INPUT_A = 5;
    localparam int SML_ST_CHROMA_ANC_FLAG = 6;
    localparam int SML_ST_HOLD = 7;

    // interrupt event positions, shared by status and mask
    localparam int SML_EV_LOCK_RISE = 0;
    localparam int SML_EV_LOCK_FALL = 1;
    localparam int SML_EV_CARRIER_LOST = 2;
    localparam int SML_EV_CFG_CHANGE = 3;
    localparam int SML_EV_W = 4;

    // control field positions
    localparam int SML_CT_FORCE_MUTE = 0;

    // reset values
    localparam logic [SML_EV_W-1:0] SML_RST_IRQ_MASK = 4'h0;
    localparam logic SML_RST_FORCE_MUTE = 1'b0;

    // pins from outside the clock domain
    typedef struct packed {
        logic master_sel;
        logic input_select;
        logic carrier_detect_a;
        logic carrier_detect_b;
        logic asi_mode_pin;
        logic rate_select_pin;
        logic video_processing_pin;
        logic bus_width_select;
    } sml_pin_s;

    // status from the deserializer core, same clock
    typedef struct packed {
        logic smpte_lock;
        logic asi_lock;
        logic rate_sd;
        logic anc_chroma;
        logic anc_any;
    } sml_core_s;

    // pin drive towards the application logic
    typedef struct packed {
        logic asi_mode_pin_o;
        logic asi_mode_pin_oe_n;
        logic rate_select_pin_o;
        logic rate_select_pin_oe_n;
    } sml_drive_s;
endpackage

// File: rtl/sml_mode_lock.sv
// Operation
// - master select high: device detects format, drives mode and rate pins
// - asi mode pin is input in slave mode, output in master mode
// - master: asi mode pin high only while locked to asi stream
// - slave with asi mode pin low: no asi alignment or decoding
// - lock indicator high while locked to compliant data of active mode
// - hd: chroma anc flag follows anc in chroma stream
// - sd 20-bit: chroma anc flag follows anc in chroma stream only
// - sd 10-bit: chroma anc flag follows anc anywhere in stream
// - master: rate pin low for hd rates, high for 270 Mb/s
// - slave rate pin low: lock to hd rates only
// - slave rate pin high: lock to 270 Mb/s only
// - input a valid while carrier detect a is low
// - selected carrier detect high: invalid, lock low, outputs muted
// - input select high picks input a and detect a, else b
//
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module sml_mode_lock #(
    parameter int ADDR_W = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire sml_pkg::sml_pin_s pins,
    input wire sml_pkg::sml_core_s core,
    output sml_pkg::sml_drive_s drive,
    output logic locked,
    output logic chroma_anc_flag,
    output logic serial_input_a_sel,
    output logic asi_decode_en,
    output logic out_mute,
    output logic irq,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import sml_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (ADDR_W < 4) begin : g_chk
        $error("ADDR_W must cover the four register words");
    end

    // ------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------
    logic rst_s1_q;
    logic rst_q;
    sml_pin_s pin_s1_q;
    sml_pin_s pin_q;
    sml_pin_s pin_prev_q;
    logic [2:0] pin_age_q;

    // async assert, synchronous release
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_q <= rst_s1_q;
        end
    end

    // pins are asynchronous; only pin_q and later copies are read
    always_ff @(posedge mclk or negedge rst_q) begin
        if (!rst_q) begin
            pin_s1_q <= '0;
            pin_q <= '0;
            pin_prev_q <= '0;
        end else begin
            pin_s1_q <= pins;
            pin_q <= pin_s1_q;
            pin_prev_q <= pin_q;
        end
    end

    // pin_prev_q holds a real pin level only from the third edge on;
    // without this, the first synced pins would look like a reconfiguration
    always_ff @(posedge mclk or negedge rst_q) begin
        if (!rst_q) begin
            pin_age_q <= '0;
        end else begin
            pin_age_q <= {pin_age_q[1:0], 1'b1};
        end
    end

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    logic master;
    logic slave_asi;
    logic asi_active;
    logic rate_sd;
    logic carrier_bad;
    logic rate_ok;
    logic lock_raw;
    logic cfg_change;
    logic force_mute_q;
    logic hold_q;
    logic locked_d;

    assign master = pin_q.master_sel;
    // slave asi only with the full documented pin combination
    assign slave_asi = pin_q.asi_mode_pin & pin_q.rate_select_pin
        & ~pin_q.video_processing_pin;
    assign asi_active = master ? core.asi_lock : slave_asi;
    assign rate_sd = master ? core.rate_sd : pin_q.rate_select_pin;
    // selected carrier detect, high means no signal
    assign carrier_bad = pin_q.input_select ? pin_q.carrier_detect_a
        : pin_q.carrier_detect_b;
    // slave mode only accepts the configured rate
    assign rate_ok = master | (core.rate_sd == pin_q.rate_select_pin);
    assign lock_raw = asi_active ? core.asi_lock : core.smpte_lock;
    assign cfg_change = pin_age_q[2] & ~master
        & (pin_q.asi_mode_pin != pin_prev_q.asi_mode_pin
        | pin_q.rate_select_pin != pin_prev_q.rate_select_pin
        | pin_q.video_processing_pin != pin_prev_q.video_processing_pin);
    assign locked_d = lock_raw & rate_ok & ~carrier_bad & ~hold_q & ~cfg_change;

    // ------------------------------------------------------------
    // relock hold after a slave reconfiguration
    // ------------------------------------------------------------
    // the core must drop lock once before the new setup is trusted,
    // so a stale lock from the old rate never shows as valid
    always_ff @(posedge mclk or negedge rst_q) begin
        if (!rst_q) begin
            hold_q <= 1'b0;
        end else if (cfg_change) begin
            hold_q <= 1'b1;
        end else if (!lock_raw || master) begin
            hold_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    // lock, mute and input routing
    always_ff @(posedge mclk or negedge rst_q) begin
        if (!rst_q) begin
            locked <= 1'b0;
            out_mute <= 1'b1;
            serial_input_a_sel <= 1'b0;
            asi_decode_en <= 1'b0;
        end else begin
            locked <= locked_d;
            out_mute <= carrier_bad | force_mute_q;
            serial_input_a_sel <= pin_q.input_select;
            asi_decode_en <= master | slave_asi;
        end
    end

    // chroma ancillary flag; 10-bit sd carries both streams in one word
    always_ff @(posedge mclk or negedge rst_q) begin
        if (!rst_q) begin
            chroma_anc_flag <= 1'b0;
        end else if (carrier_bad) begin
            chroma_anc_flag <= 1'b0;
        end else if (rate_sd && !pin_q.bus_width_select) begin
            chroma_anc_flag <= core.anc_any;
        end else begin
            chroma_anc_flag <= core.anc_chroma;
        end
    end

    // two-way pins: driven only in master mode, enable is active low
    always_ff @(posedge mclk or negedge rst_q) begin
        if (!rst_q) begin
            drive <= '{1'b0, 1'b1, 1'b0, 1'b1};
        end else begin
            drive.asi_mode_pin_oe_n <= ~master;
            drive.rate_select_pin_oe_n <= ~master;
            drive.asi_mode_pin_o <= master & core.asi_lock & ~carrier_bad;
            drive.rate_select_pin_o <= master & core.rate_sd;
        end
    end

    // ------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------
    logic [SML_EV_W-1:0] ev;
    logic [SML_EV_W-1:0] irq_stat_q;
    logic [SML_EV_W-1:0] irq_mask_q;
    logic carrier_bad_q;
    logic acc;
    logic wr_hit;

    always_ff @(posedge mclk or negedge rst_q) begin
        if (!rst_q) begin
            carrier_bad_q <= 1'b0;
        end else begin
            carrier_bad_q <= carrier_bad;
        end
    end

    assign ev[SML_EV_LOCK_RISE] = locked_d & ~locked;
    assign ev[SML_EV_LOCK_FALL] = ~locked_d & locked;
    assign ev[SML_EV_CARRIER_LOST] = carrier_bad & ~carrier_bad_q;
    assign ev[SML_EV_CFG_CHANGE] = cfg_change;

    // ------------------------------------------------------------
    // avalon slave: one wait state, then the access completes
    // ------------------------------------------------------------
    assign acc = (avs_read | avs_write) & ~avs_waitrequest;
    assign wr_hit = avs_write & ~avs_waitrequest;

    always_ff @(posedge mclk or negedge rst_q) begin
        if (!rst_q) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
        end
    end

    // read data is loaded as waitrequest falls, so it stands at the take edge
    always_ff @(posedge mclk or negedge rst_q) begin
        if (!rst_q) begin
            avs_readdata <= '0;
        end else if (avs_read && avs_waitrequest) begin
            unique case (avs_address[3:0])
                SML_OFS_STATUS: begin
                    avs_readdata <= {24'h000000, hold_q, chroma_anc_flag,
                        serial_input_a_sel, ~carrier_bad, master, rate_sd,
                        asi_active, locked};
                end
                SML_OFS_IRQ_STAT: avs_readdata <= {28'h0000000, irq_stat_q};
                SML_OFS_IRQ_MASK: avs_readdata <= {28'h0000000, irq_mask_q};
                SML_OFS_CTRL: avs_readdata <= {31'h00000000, force_mute_q};
                default: avs_readdata <= '0;
            endcase
        end
    end

    // sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge mclk or negedge rst_q) begin
        if (!rst_q) begin
            irq_stat_q <= '0;
        end else if (wr_hit && avs_address[3:0] == SML_OFS_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~avs_writedata[SML_EV_W-1:0]) | ev;
        end else begin
            irq_stat_q <= irq_stat_q | ev;
        end
    end

    // mask and control
    always_ff @(posedge mclk or negedge rst_q) begin
        if (!rst_q) begin
            irq_mask_q <= SML_RST_IRQ_MASK;
            force_mute_q <= SML_RST_FORCE_MUTE;
        end else if (wr_hit && avs_address[3:0] == SML_OFS_IRQ_MASK) begin
            irq_mask_q <= avs_writedata[SML_EV_W-1:0];
        end else if (wr_hit && avs_address[3:0] == SML_OFS_CTRL) begin
            force_mute_q <= avs_writedata[SML_CT_FORCE_MUTE];
        end
    end

    // level interrupt, one cycle behind the status bits
    always_ff @(posedge mclk or negedge rst_q) begin
        if (!rst_q) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_q);

    a_lock_needs_carrier: assert property (carrier_bad |=> !locked)
        else $error("lock shown without carrier");
    a_mute_on_carrier: assert property (carrier_bad |=> out_mute)
        else $error("outputs not muted without carrier");
    a_asi_pin_master: assert property (master && !core.asi_lock |=> !drive.asi_mode_pin_o)
        else $error("asi pin high without asi lock");
    a_asi_pin_lock: assert property (master && core.asi_lock && !carrier_bad
        |=> drive.asi_mode_pin_o)
        else $error("asi pin low while asi locked");
    a_pin_dir: assert property (!master |=> drive.asi_mode_pin_oe_n
        && drive.rate_select_pin_oe_n)
        else $error("pin driven in slave mode");
    a_rate_pin_value: assert property (master
        |=> drive.rate_select_pin_o == $past(core.rate_sd))
        else $error("rate pin wrong in master mode");
    a_slave_rate_lock: assert property (!master
        && core.rate_sd != pin_q.rate_select_pin |=> !locked)
        else $error("lock on wrong rate");
    a_no_asi_decode: assert property (!master && !pin_q.asi_mode_pin |=> !asi_decode_en)
        else $error("asi decode enabled in slave mode");
    a_cfg_hold: assert property (cfg_change |=> !locked ##0 hold_q)
        else $error("lock kept over reconfiguration");
    a_chroma_anc_flag_10bit: assert property (rate_sd && !pin_q.bus_width_select
        && !carrier_bad |=> chroma_anc_flag == $past(core.anc_any))
        else $error("chroma anc flag wrong in 10-bit sd");
    a_chroma_anc_flag_chroma: assert property (!(rate_sd && !pin_q.bus_width_select)
        && !carrier_bad |=> chroma_anc_flag == $past(core.anc_chroma))
        else $error("chroma anc flag wrong");
    a_irq_level: assert property (|(irq_stat_q & irq_mask_q) |=> irq)
        else $error("interrupt not raised for unmasked event");
    a_input_sel: assert property (pin_q.input_select |=> serial_input_a_sel)
        else $error("input a not selected");
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer timing wrong");
endmodule

// File: dv/sml_app_model.sv
`timescale 1ns/1ps
// application side of the mode pins: sets them in slave mode, reads them in master mode
module sml_app_model (
    input wire logic mclk,
    input wire logic master_sel,
    input wire sml_pkg::sml_drive_s drive,
    input wire logic [2:0] cfg,
    output logic asi_mode_pin,
    output logic rate_select_pin,
    output logic video_processing_pin
);
    import sml_pkg::*;
    logic flip = 1'b0;

    // a released pin with no pull must not look stable, so it toggles
    always @(posedge mclk) begin
        flip <= ~flip;
    end

    // device drive wins; in slave mode the app drives its chosen levels
    always_comb begin
        asi_mode_pin = flip;
        rate_select_pin = 1'b1; // pull-up when released
        if (!master_sel) begin
            asi_mode_pin = cfg[2];
            rate_select_pin = cfg[1];
        end
        if (!drive.asi_mode_pin_oe_n) begin
            asi_mode_pin = drive.asi_mode_pin_o;
        end
        if (!drive.rate_select_pin_oe_n) begin
            rate_select_pin = drive.rate_select_pin_o;
        end
        video_processing_pin = cfg[0];
    end
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
    import sml_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic m, isel, cda, cdb, bw, asi_c, rate_c, proc_c, hold;
    logic asi_w, rate_w, proc_w, locked, chroma_anc_flag, ina, dec_en, out_mute, irq;
    logic avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [2:0] cfgs [4] = '{3'b110, 3'b010, 3'b100, 3'b111};
    sml_core_s core;
    sml_drive_s drive;
    sml_pin_s pins;
    int bad_count = 0;
    int cmp_count = 0;

    assign pins = {m, isel, cda, cdb, asi_w, rate_w, proc_w, bw};

    // 20 MHz clock
    always #25 mclk = ~mclk;

    sml_mode_lock i_sml_mode_lock (.mclk(mclk), .rst_n(rst_n), .pins(pins), .core(core),
        .drive(drive), .locked(locked), .chroma_anc_flag(chroma_anc_flag),
        .serial_input_a_sel(ina), .asi_decode_en(dec_en), .out_mute(out_mute), .irq(irq),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    sml_app_model i_sml_app_model (.mclk(mclk), .master_sel(m), .drive(drive),
        .cfg({asi_c, rate_c, proc_c}), .asi_mode_pin(asi_w), .rate_select_pin(rate_w),
        .video_processing_pin(proc_w));

    // ------------------------------------------------------------
    // reference model and checks
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic test_done();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one bus access; the request stays put until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // expected pin drive, lock, chroma flag, input choice and mute
    function automatic logic [7:0] model();
        logic ok, am, sd, lk;
        ok = isel ? !cda : !cdb;
        am = !m && asi_c && rate_c && !proc_c;
        sd = m ? core.rate_sd : rate_c;
        lk = m ? core.smpte_lock || core.asi_lock
               : core.rate_sd == rate_c && (am ? core.asi_lock : core.smpte_lock);
        return {m && core.asi_lock && ok, m, m && core.rate_sd, m, ok && !hold && lk,
                ok && (sd && !bw ? core.anc_any : core.anc_chroma), isel, !ok};
    endfunction

    task automatic chk_out();
        logic [7:0] s;
        logic [7:0] e;
        e = model();
        s = {drive.asi_mode_pin_o & ~drive.asi_mode_pin_oe_n, ~drive.asi_mode_pin_oe_n,
             drive.rate_select_pin_o & ~drive.rate_select_pin_oe_n,
             ~drive.rate_select_pin_oe_n, locked, chroma_anc_flag, ina, out_mute};
        chk(32'(s), 32'(e));
        chk(32'(dec_en), 32'(m || (asi_c && rate_c && !proc_c)));
    endtask

    // status word over the bus, held against the same model
    task automatic chk_status();
        logic [7:0] e;
        e = model();
        bus(1'b0, SML_OFS_STATUS, 32'h0);
        chk(rd, {24'h0, hold, e[2], e[1], ~e[0], m, m ? core.rate_sd : rate_c,
            m ? core.asi_lock : asi_c && rate_c && !proc_c, e[3]});
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        step(3);
        rst_n <= 1'b1;
        step(6);
    endtask

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        {m, isel, cda, cdb, bw, asi_c, rate_c, proc_c, hold} = 9'h100;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        core = '0;
        void'($urandom(87));
        do_reset();
        bus(1'b0, SML_OFS_IRQ_MASK, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, SML_OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h0);
        // master mode with random pins and core status
        for (int i = 0; i < 40; i++) begin
            {isel, cda, cdb, bw} <= 4'($urandom);
            core <= 5'($urandom);
            step(6);
            chk_out();
            chk_status();
        end
        // carrier loss raises a masked-in interrupt, write one clears it
        {isel, cda} <= 2'b10;
        core <= 5'h10;
        step(6);
        bus(1'b1, SML_OFS_IRQ_STAT, 32'hF);
        bus(1'b1, SML_OFS_IRQ_MASK, 32'h4);
        step(2);
        chk(32'(irq), 32'h0);
        cda <= 1'b1;
        step(6);
        chk(32'(irq), 32'h1);
        bus(1'b0, SML_OFS_IRQ_STAT, 32'h0);
        chk(rd & 32'h4, 32'h4);
        bus(1'b1, SML_OFS_IRQ_STAT, 32'h4);
        bus(1'b1, SML_OFS_IRQ_MASK, 32'h0);
        cda <= 1'b0;
        step(6);
        cda <= 1'b1;
        step(6);
        chk(32'(irq), 32'h0);
        cda <= 1'b0;
        bus(1'b1, SML_OFS_CTRL, 32'h1);
        step(2);
        chk(32'(out_mute), 32'h1);
        bus(1'b1, SML_OFS_CTRL, 32'h0);
        step(2);
        chk(32'(out_mute), 32'h0);
        // slave configurations, each set up before a device reset
        m <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            {asi_c, rate_c, proc_c} <= cfgs[i];
            core <= '0;
            step(1);
            do_reset();
            step(4);
            chk_out();
            core <= {2'b01, rate_c, 2'b11};
            step(6);
            chk_out();
            core <= {2'b10, rate_c, 2'b01};
            step(6);
            chk_out();
            core <= {2'b10, ~rate_c, 2'b01};
            step(6);
            chk_out();
        end
        // config change while locked holds lock low until the core relocks
        core <= 5'h14;
        step(6);
        chk_out();
        asi_c <= 1'b0;
        hold <= 1'b1;
        step(6);
        chk_out();
        chk_status();
        core.smpte_lock <= 1'b0;
        hold <= 1'b0;
        step(4);
        core.smpte_lock <= 1'b1;
        step(6);
        chk_out();
        // slave mode with random status under a fixed config
        for (int i = 0; i < 30; i++) begin
            {isel, cda, cdb, bw} <= 4'($urandom);
            core <= 5'($urandom);
            step(6);
            chk_out();
        end
        test_done();
    end

    // watchdog: the sequence needs well under 5000 cycles
    initial begin
        step(5000);
        bad_count++;
        test_done();
    end
endmodule
